// ### tts_top.sv
module tts_top
  import tts_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // control from acquisition logic (same clock)
  input wire logic ts_reset_cmd,
  input wire logic sample_tick,
  input wire logic trigger_evt,
  input wire logic sec_mode,
  // external seconds pulse (asynchronous pin)
  input wire logic pps_pin,
  // timestamp readout
  output logic [TS_W-1:0] rd_data,
  output logic rd_valid,
  input wire logic rd_ready,
  // status
  output logic fifo_full,
  output logic overflow
);

  ////////////////////////////////////////////////////////////////////////////
  // steps shared by the counter, the write side and the read side
  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] ptr);
    ptr_inc = ptr + PTR_ONE;
  endfunction

  function automatic logic [HALF_W-1:0] half_inc(input logic [HALF_W-1:0] half);
    half_inc = half + HALF_ONE;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic pps_s1_reg;
  logic pps_s2_reg;
  logic pps_d_reg;
  logic pps_rise;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pps_s1_reg <= 1'b0;
      pps_s2_reg <= 1'b0;
      pps_d_reg <= 1'b0;
    end else if (clk_en) begin
      pps_s1_reg <= pps_pin;
      pps_s2_reg <= pps_s1_reg;
      pps_d_reg <= pps_s2_reg;
    end
  end

  assign pps_rise = pps_s2_reg & ~pps_d_reg;

  ////////////////////////////////////////////////////////////////////////////
  logic [TS_W-1:0] ts_reg;
  logic [TS_W-1:0] ts_next;

  always_comb begin
    ts_next = ts_reg;
    if (ts_reset_cmd) begin
      ts_next = TS_ZERO; // [R1]
    end else if (sec_mode) begin
      if (pps_rise) begin
        // seconds up, sub-second restarts at the pulse
        ts_next = {half_inc(ts_reg[TS_W-1:HALF_W]), HALF_ZERO}; // [R5] [R6] [R7] [R8]
      end else if (sample_tick) begin
        ts_next = {ts_reg[TS_W-1:HALF_W], half_inc(ts_reg[HALF_W-1:0])}; // [R8]
      end
    end else if (sample_tick) begin
      ts_next = ts_reg + TS_ONE; // [R2]
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ts_reg <= TS_ZERO;
    end else if (clk_en) begin
      ts_reg <= ts_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory of captured values; a trigger while full is dropped and flagged
  // rather than stalling acquisition, which cannot wait for software
  logic [TS_W-1:0] mem [FIFO_DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [PTR_W:0] cnt_reg;
  logic push;
  logic pop;

  assign pop = rd_valid & rd_ready;
  assign push = trigger_evt & (cnt_reg != CNT_FULL);

  always_ff @(posedge clk) begin
    if (clk_en && push) begin
      mem[wr_ptr_reg] <= ts_reg; // [R3]
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= CNT_ZERO;
    end else if (clk_en) begin
      if (push) begin
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= ptr_inc(rd_ptr_reg); // [R4]
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + CNT_ONE;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - CNT_ONE;
      end
    end
  end

  // output stage: registered head of fifo, independent of acquisition
  logic [PTR_W:0] cnt_after;
  logic head_from_ts;
  logic [PTR_W-1:0] head_ptr;
  logic [TS_W-1:0] rd_data_next;

  assign cnt_after = cnt_reg + (push ? CNT_ONE : CNT_ZERO) - (pop ? CNT_ONE : CNT_ZERO);
  // a value pushed into an empty or emptying store goes straight to the
  // output register, since its memory write lands on that same edge
  assign head_from_ts = (cnt_reg == CNT_ZERO) || (pop && cnt_reg == CNT_ONE);
  assign head_ptr = pop ? ptr_inc(rd_ptr_reg) : rd_ptr_reg;

  always_comb begin
    rd_data_next = rd_data;
    if (pop || !rd_valid) begin
      if (head_from_ts) begin
        rd_data_next = ts_reg;
      end else begin
        rd_data_next = mem[head_ptr];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= TS_ZERO;
      rd_valid <= 1'b0;
      fifo_full <= 1'b0;
      overflow <= 1'b0;
    end else if (clk_en) begin
      rd_valid <= (cnt_after != CNT_ZERO); // [R4]
      rd_data <= rd_data_next; // [R3] [R4]
      fifo_full <= (cnt_after == CNT_FULL);
      if (trigger_evt && cnt_reg == CNT_FULL) begin
        overflow <= 1'b1;
      end else if (ts_reset_cmd) begin
        overflow <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // building blocks for the multi-step checks
  sequence pps_edge_s;
    clk_en && sec_mode && pps_rise && !ts_reset_cmd;
  endsequence

  sequence sub_tick_s;
    clk_en && sec_mode && sample_tick && !pps_rise && !ts_reset_cmd;
  endsequence

  sequence trig_empty_s;
    clk_en && trigger_evt && cnt_reg == CNT_ZERO;
  endsequence

  sequence pop_only_s;
    clk_en && pop && !push;
  endsequence

  sequence frozen_s;
    !clk_en;
  endsequence

  // counter
  chk_reset_clears: assert property (@(posedge clk) disable iff (!rst_b) // [R1]
    clk_en && ts_reset_cmd |=> ts_reg == TS_ZERO) else $error("counter not cleared");
  chk_tick_advance: assert property (@(posedge clk) disable iff (!rst_b) // [R2]
    clk_en && sample_tick && !ts_reset_cmd && !sec_mode |=> ts_reg == $past(ts_reg) + TS_ONE)
    else $error("counter did not advance");
  chk_tick_idle: assert property (@(posedge clk) disable iff (!rst_b) // [R2]
    clk_en && !sample_tick && !ts_reset_cmd && !(sec_mode && pps_rise) |=> $stable(ts_reg))
    else $error("counter moved without a tick");
  chk_freeze_all: assert property (@(posedge clk) disable iff (!rst_b) // [R2]
    frozen_s |=> $stable(ts_reg) && $stable(cnt_reg) && $stable(rd_valid)
      && $stable(rd_data) && $stable(overflow))
    else $error("state moved while disabled");

  // seconds mode
  chk_sec_incr: assert property (@(posedge clk) disable iff (!rst_b) // [R5] [R6] [R8]
    pps_edge_s |=> ts_reg[TS_W-1:HALF_W] == $past(ts_reg[TS_W-1:HALF_W]) + HALF_ONE)
    else $error("seconds not incremented");
  chk_sub_clear: assert property (@(posedge clk) disable iff (!rst_b) // [R7]
    pps_edge_s |=> ts_reg[HALF_W-1:0] == HALF_ZERO) else $error("sub-second not cleared");
  chk_sub_advance: assert property (@(posedge clk) disable iff (!rst_b) // [R5] [R8]
    sub_tick_s |=> ts_reg[HALF_W-1:0] == $past(ts_reg[HALF_W-1:0]) + HALF_ONE
      && ts_reg[TS_W-1:HALF_W] == $past(ts_reg[TS_W-1:HALF_W]))
    else $error("sub-second did not advance");

  // capture store and readout
  chk_push_on_trig: assert property (@(posedge clk) disable iff (!rst_b) // [R3]
    clk_en && trigger_evt && cnt_reg != CNT_FULL && !pop |=> cnt_reg == $past(cnt_reg) + CNT_ONE)
    else $error("trigger not captured");
  chk_first_capture: assert property (@(posedge clk) disable iff (!rst_b) // [R3] [R4]
    trig_empty_s |=> rd_valid && rd_data == $past(ts_reg)) else $error("captured value not presented");
  chk_drop_full: assert property (@(posedge clk) disable iff (!rst_b) // [R3]
    clk_en && trigger_evt && cnt_reg == CNT_FULL && !pop |=> overflow && cnt_reg == CNT_FULL)
    else $error("trigger while full not flagged");
  chk_count_range: assert property (@(posedge clk) disable iff (!rst_b) // [R3]
    cnt_reg <= CNT_FULL) else $error("store count out of range");
  chk_flags_match: assert property (@(posedge clk) disable iff (!rst_b) // [R3] [R4]
    fifo_full == (cnt_reg == CNT_FULL) && rd_valid == (cnt_reg != CNT_ZERO))
    else $error("status flags disagree with count");
  chk_valid_held: assert property (@(posedge clk) disable iff (!rst_b) // [R4]
    rd_valid && !rd_ready && clk_en && !ts_reset_cmd |=> rd_valid && $stable(rd_data))
    else $error("read data dropped");
  chk_pop_count: assert property (@(posedge clk) disable iff (!rst_b) // [R4]
    pop_only_s |=> cnt_reg == $past(cnt_reg) - CNT_ONE) else $error("read did not retire an entry");

endmodule

// ### tts_pkg.sv
// Overview of operation
// (R1) a reset command clears the timestamp counter to zero
// (R2) the counter advances once per sample period
// (R3) each trigger pushes the current counter value into a timestamp fifo; a trigger while the fifo is full is dropped and sets overflow
// (R4) stored timestamps are read out independently of sampling
// (R5) in seconds mode the 64-bit value splits into seconds and sub-second parts
// (R6) in seconds mode the seconds part counts pulses since the last reset command
// (R7) in seconds mode each rising pulse edge clears the sub-second part
// (R8) seconds occupy the upper 32 bits, sub-second count the lower 32 bits
package tts_pkg;
  localparam int TS_W = 64;
  localparam int HALF_W = 32;
  localparam int FIFO_DEPTH = 16;
  localparam int PTR_W = 4;
  localparam logic [HALF_W-1:0] HALF_ZERO = 32'h0000_0000;
  localparam logic [HALF_W-1:0] HALF_ONE = 32'h0000_0001;
  localparam logic [TS_W-1:0] TS_ZERO = 64'h0000_0000_0000_0000;
  localparam logic [TS_W-1:0] TS_ONE = 64'h0000_0000_0000_0001;
  localparam logic [PTR_W:0] CNT_ZERO = 5'h00;
  localparam logic [PTR_W:0] CNT_FULL = 5'h10;
  localparam logic [PTR_W-1:0] PTR_ONE = 4'h1;
  localparam logic [PTR_W:0] CNT_ONE = 5'h01;
endpackage

// ### tts_pps_src.sv
module tts_pps_gen (
  // clock
  input wire logic clk,
  // request a pulse
  input wire logic fire,
  // seconds pulse pin
  output logic pps_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] hold_reg = 4'h0;
  // pulse held long enough to pass the two-stage synchroniser
  always @(posedge clk) begin
    if (fire)
      hold_reg <= 4'h8;
    else if (hold_reg != 4'h0)
      hold_reg <= hold_reg - 4'h1;
  end
  assign pps_pin = (hold_reg != 4'h0);
endmodule

// ### trigger_timestamp_counter_tb.sv
module trigger_timestamp_counter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tts_pkg::*;
  logic clk = 0, rst_b = 0, cmd = 0, tick = 0, trg = 0, sec = 0, rdy = 0, fire = 0, en = 1;
  logic pps, rd_valid, fifo_full, overflow;
  logic [TS_W-1:0] rd_data;
  int failures = 0, num_checks = 0;
  always #2.5 clk = ~clk;
  tts_top dut_u(.clk(clk), .rst_b(rst_b), .clk_en(en), .ts_reset_cmd(cmd), .sample_tick(tick),
    .trigger_evt(trg), .sec_mode(sec), .pps_pin(pps), .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_ready(rdy), .fifo_full(fifo_full), .overflow(overflow));
  tts_pps_gen pps_u(.clk(clk), .fire(fire), .pps_pin(pps));
  //////////////////////////////////////////////////////////////////
  task finish_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task check(input logic [TS_W-1:0] seen, input logic [TS_W-1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task step(input logic c, input logic t, input logic g, input logic p);
    @(negedge clk);
    {cmd, tick, trg, fire} = {c, t, g, p};
  endtask
  // bounded wait for the head word, then take it with one ready cycle
  task pop(input logic [TS_W-1:0] exp);
    int i;
    for (i = 0; i < 20 && rd_valid !== 1'b1; i++)
      @(negedge clk);
    if (i == 20) begin
      failures++;
      finish_test();
    end else begin
      check(rd_data, exp);
      @(negedge clk) rdy = 1;
      @(negedge clk) rdy = 0;
    end
  endtask
  //////////////////////////////////////////////////////////////////
  task sc_count;
    repeat (5) step(0, 1, 0, 0);
    step(0, 1, 1, 0);
    step(0, 0, 0, 0);
    pop(64'h0000_0000_0000_0005);
  endtask
  task sc_clear;
    step(1, 0, 0, 0);
    step(0, 1, 1, 0);
    step(0, 0, 0, 0);
    pop(64'h0000_0000_0000_0000);
  endtask
  task sc_seconds;
    sec = 1;
    step(1, 0, 0, 0);
    repeat (3) step(0, 1, 0, 0);
    step(0, 0, 0, 1);
    repeat (6) step(0, 0, 0, 0);
    repeat (2) step(0, 1, 0, 0);
    step(0, 0, 1, 0);
    step(0, 0, 0, 0);
    pop(64'h0000_0001_0000_0002);
    sec = 0;
  endtask
  // seventeenth trigger finds the store full and is lost
  task sc_full;
    step(1, 0, 0, 0);
    repeat (17) step(0, 1, 1, 0);
    step(0, 0, 0, 0);
    check({63'h0, fifo_full}, 64'h0000_0000_0000_0001);
    check({63'h0, overflow}, 64'h0000_0000_0000_0001);
    for (int k = 0; k < 16; k++)
      pop(TS_W'(k));
    check({63'h0, fifo_full}, 64'h0000_0000_0000_0000);
    step(1, 0, 0, 0);
    step(0, 0, 0, 0);
    check({63'h0, overflow}, 64'h0000_0000_0000_0000);
  endtask
  // enable low must freeze counter and store: ticks and triggers are ignored
  task sc_freeze;
    step(1, 0, 0, 0);
    step(0, 1, 1, 0);
    en = 0;
    repeat (3) step(0, 1, 1, 0);
    step(0, 1, 0, 0);
    en = 1;
    step(0, 0, 1, 0);
    step(0, 0, 0, 0);
    pop(64'h0000_0000_0000_0001);
  endtask
  // reset in mid-run empties the store and zeroes the counter
  task sc_reset;
    repeat (2) step(0, 1, 1, 0);
    step(0, 0, 0, 0);
    rst_b = 0;
    step(0, 0, 0, 0);
    rst_b = 1;
    check({63'h0, rd_valid}, 64'h0000_0000_0000_0000);
    step(0, 1, 1, 0);
    step(0, 0, 0, 0);
    pop(64'h0000_0000_0000_0000);
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rst_b = 1;
    sc_count();
    sc_clear();
    sc_seconds();
    sc_full();
    sc_freeze();
    sc_reset();
    finish_test();
  end
endmodule
